/* hw/fscd_clkdiv.sv */
// Purpose: Turns the bus clock into flash timing ticks, one cycle long except at divisor 0 without prescale.
// Assumes: Divisor and prescale are stable once loaded.
// Notes: Ticks run only while the divisor has been loaded.
module fscd_clkdiv (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic i_prescale,
  input wire logic [5:0] i_divisor,
  output logic o_fclk_tick
);

  logic [2:0] pre_q;
  logic [2:0] pre_d;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic tick_q;
  logic tick_d;
  logic step;

  // ----------------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------------
  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    tick_d = 1'b0;
    step = 1'b0;
    if (i_run) begin
      if (i_prescale) begin
        step = (pre_q == fscd_pkg::PRESCALE_LAST);
        pre_d = pre_q + 3'h1;
      end else begin
        step = 1'b1;
        pre_d = 3'h0;
      end
      if (step) begin
        if (cnt_q >= i_divisor) begin
          cnt_d = 6'h00;
          tick_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 6'h01;
        end
      end
    end else begin
      pre_d = 3'h0;
      cnt_d = 6'h00;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pre_q <= 3'h0;
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  // One bus cycle per flash tick, except divisor 0 without prescale, where the tick stays high.
  assign o_fclk_tick = tick_q;

  a_tick_single: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (tick_q && i_prescale) |=> !tick_q)
    else $error("flash tick lasted more than one cycle");

endmodule : fscd_clkdiv

/* hw/fscd_pkg.sv */
// Purpose: Shared constants for the flash security gate and clock divider.
// Assumes: APB with 32-bit data, one register to an aligned word.
// Notes: Byte data sits in the low eight bits of each word.
package fscd_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_CLK_DIV = 12'h000;
  localparam logic [11:0] OFF_OPTION = 12'h004;
  localparam logic [11:0] OFF_CONFIG = 12'h008;
  localparam logic [11:0] OFF_PROTECT = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int DIV_LOADED_BIT = 7;
  localparam int DIV_PRESCALE_BIT = 6;
  localparam int OPT_BACKDOOR_EN_BIT = 7;
  localparam int OPT_REDIRECT_DIS_BIT = 6;
  localparam int CFG_KEY_ACCESS_BIT = 5;
  localparam logic [7:0] OPT_READ_MASK = 8'hC3;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hE0;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;

  // ----------------------------------------------------------------------
  // Reset values and key window
  // ----------------------------------------------------------------------
  localparam logic [7:0] CLK_DIV_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [15:0] KEY_ADDR_LO = 16'hFFB0;
  localparam logic [15:0] KEY_ADDR_HI = 16'hFFB7;
  localparam logic [3:0] KEY_BYTES = 4'h8;
  localparam logic [2:0] PRESCALE_LAST = 3'h7;

endpackage : fscd_pkg

/* hw/fscd_top.sv */
// Purpose: Security gate, backdoor key check and flash clock divider.
// Assumes: Memory requests and straps are synchronous to i_ref_clk.
// Notes: APB answers with zero wait states; read data is registered in
//   the setup cycle so it comes from flip-flops.
//
// Chosen here: register access over APB and the address map.

module fscd_top (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_pfrom_debug,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [7:0] i_nonvolatile_option_byte,
  input wire logic [7:0] i_nonvolatile_protect_byte,
  input wire logic [63:0] i_backdoor_key_locations,
  input wire logic i_background_mode_pin,
  input wire logic i_mem_valid,
  input wire logic i_mem_write,
  input wire logic [15:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  input wire logic i_mem_from_secure,
  input wire logic i_mem_from_debug,
  input wire logic i_mem_target_secure,
  input wire logic [7:0] i_array_rdata,
  input wire logic i_blank_check_ok,
  input wire logic i_debug_enable_req,
  input wire logic i_background_req,
  output logic o_mem_valid,
  output logic [7:0] o_mem_rdata,
  output logic o_cmd_start,
  output logic o_cmd_refused,
  output logic o_secure,
  output logic o_debug_enable,
  output logic o_background_enter,
  output logic o_program_erase_enable,
  output logic o_fclk_tick
);

  typedef enum logic [1:0] {
    KS_IDLE = 2'b01,
    KS_ENTRY = 2'b10
  } fscd_key_e;
  default clocking chk_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic [7:0] opt_q;
  logic [7:0] opt_d;
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [7:0] prot_q;
  logic [7:0] prot_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic unlock_q;
  logic unlock_d;
  logic boot_bgnd_q;
  logic boot_bgnd_d;
  fscd_key_e key_st_q;
  fscd_key_e key_st_d;
  logic [3:0] key_cnt_q;
  logic [3:0] key_cnt_d;
  logic key_bad_q;
  logic key_bad_d;
  logic [7:0] mem_rdata_q;
  logic [7:0] mem_rdata_d;

  logic setup;
  logic wr_acc;
  logic hit;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic [1:0] sec_bits;
  logic secure;
  logic blocked;
  logic in_key;
  logic key_access;
  logic key_wr;
  logic key_fall;
  logic key_good;
  logic [7:0] key_byte;

  assign setup = i_psel && !i_penable;
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign wbyte = i_pwdata[7:0];
  assign key_access = cfg_q[fscd_pkg::CFG_KEY_ACCESS_BIT];

  // ----------------------------------------------------------------------
  // Security decode
  // ----------------------------------------------------------------------
  // Only 1:0 leaves the part open.
  assign sec_bits = unlock_q ? fscd_pkg::SEC_UNSECURED : opt_q[1:0];
  assign secure = (sec_bits != fscd_pkg::SEC_UNSECURED);

  // Unsecured sources lose access to secure resources.
  // Secure code and register space are never blocked.
  assign blocked = secure && i_mem_target_secure &&
                   (!i_mem_from_secure || i_mem_from_debug);

  assign in_key = (i_mem_addr >= fscd_pkg::KEY_ADDR_LO) &&
                  (i_mem_addr <= fscd_pkg::KEY_ADDR_HI);

  // Only code running from secure memory counts as key entry.
  assign key_wr = i_mem_valid && i_mem_write && in_key && key_access &&
                  i_mem_from_secure && !i_mem_from_debug;

  // ----------------------------------------------------------------------
  // Memory gate
  // ----------------------------------------------------------------------
  // Key-range writes are swallowed while key access is set.
  // Blocked writes never reach the array.
  assign o_mem_valid = i_mem_valid &&
                       !(i_mem_write && (blocked || (in_key && key_access)));

  always_comb begin
    mem_rdata_d = 8'h00;
    if (i_mem_valid && !i_mem_write && !blocked) begin
      mem_rdata_d = i_array_rdata;
    end
  end

  // Any forwarded write to a secure target starts or refuses a command.
  // Program and erase need a loaded divisor.
  assign o_cmd_start = o_mem_valid && i_mem_write &&
                       i_mem_target_secure && div_q[7];
  assign o_cmd_refused = o_mem_valid && i_mem_write &&
                         i_mem_target_secure && !div_q[7];

  // ----------------------------------------------------------------------
  // Backdoor key engine
  // ----------------------------------------------------------------------
  assign key_fall = wr_acc && (i_paddr == fscd_pkg::OFF_CONFIG) &&
                    key_access && !wbyte[fscd_pkg::CFG_KEY_ACCESS_BIT];
  assign key_byte = i_backdoor_key_locations[8 * key_cnt_q[2:0] +: 8];
  assign key_good = opt_q[fscd_pkg::OPT_BACKDOOR_EN_BIT] && !key_bad_q &&
                    (key_cnt_q == fscd_pkg::KEY_BYTES);

  always_comb begin
    key_st_d = key_st_q;
    key_cnt_d = key_cnt_q;
    key_bad_d = key_bad_q;
    unique case (key_st_q)
      KS_IDLE: begin
        if (key_access) begin
          key_st_d = KS_ENTRY;
          key_cnt_d = 4'h0;
          key_bad_d = 1'b0;
        end
      end
      KS_ENTRY: begin
        // Bytes are expected in ascending order.
        if (key_wr) begin
          if (key_cnt_q == fscd_pkg::KEY_BYTES ||
              i_mem_addr[2:0] != key_cnt_q[2:0] ||
              i_mem_wdata != key_byte) begin
            key_bad_d = 1'b1;
          end
          if (key_cnt_q != fscd_pkg::KEY_BYTES) begin
            key_cnt_d = key_cnt_q + 4'h1;
          end
        end
        if (!key_access) begin
          key_st_d = KS_IDLE;
        end
      end
      default: begin
        key_st_d = KS_IDLE;
      end
    endcase
  end

  always_comb begin
    unlock_d = unlock_q;
    // A mismatch leaves the state alone.
    if (key_fall && key_st_q == KS_ENTRY && key_good) begin
      unlock_d = 1'b1;
    end
    if (i_blank_check_ok) begin
      unlock_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  always_comb begin
    div_d = div_q;
    cfg_d = cfg_q;
    prot_d = prot_q;
    opt_d = opt_q;
    if (wr_acc) begin
      unique case (i_paddr)
        fscd_pkg::OFF_CLK_DIV: begin
          // Loaded flag set whatever the data.
          if (!div_q[fscd_pkg::DIV_LOADED_BIT]) begin
            div_d = {1'b1, wbyte[6:0]};
          end
        end
        fscd_pkg::OFF_CONFIG: begin
          cfg_d = wbyte & fscd_pkg::CFG_WRITE_MASK;
        end
        fscd_pkg::OFF_PROTECT: begin
          if (i_pfrom_debug) begin
            prot_d = wbyte;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    hit = 1'b1;
    rd_byte = 8'h00;
    unique case (i_paddr)
      fscd_pkg::OFF_CLK_DIV: rd_byte = div_q;
      fscd_pkg::OFF_OPTION: rd_byte = {opt_q[7:2], sec_bits} &
                                      fscd_pkg::OPT_READ_MASK;
      fscd_pkg::OFF_CONFIG: rd_byte = cfg_q;
      fscd_pkg::OFF_PROTECT: rd_byte = prot_q;
      fscd_pkg::OFF_STATUS: rd_byte = {key_cnt_q, key_bad_q, unlock_q,
                                       boot_bgnd_q, secure};
      default: hit = 1'b0;
    endcase
    rdata_d = rdata_q;
    if (setup) begin
      rdata_d = {24'h000000, rd_byte};
    end
  end

  // Zero wait states keep the slave simple; a miss is flagged, not stalled.
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;
  assign o_prdata = rdata_q;

  // ----------------------------------------------------------------------
  // Debug and background control
  // ----------------------------------------------------------------------
  // Pin low during reset release allows background entry.
  assign boot_bgnd_d = boot_bgnd_q;
  // Debug module stays off while secure.
  assign o_debug_enable = i_debug_enable_req && !secure;
  assign o_background_enter = boot_bgnd_q || (i_background_req && !secure);
  assign o_secure = secure;
  assign o_program_erase_enable = div_q[fscd_pkg::DIV_LOADED_BIT];
  assign o_mem_rdata = mem_rdata_q;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      div_q <= fscd_pkg::CLK_DIV_RESET;
      cfg_q <= fscd_pkg::CONFIG_RESET;
      // Option and protection copied while reset is held.
      opt_q <= i_nonvolatile_option_byte;
      prot_q <= i_nonvolatile_protect_byte;
      // Last reset cycle samples the pin.
      boot_bgnd_q <= !i_background_mode_pin;
      rdata_q <= 32'h00000000;
      unlock_q <= 1'b0;
      key_st_q <= KS_IDLE;
      key_cnt_q <= 4'h0;
      key_bad_q <= 1'b0;
      mem_rdata_q <= 8'h00;
    end else begin
      div_q <= div_d;
      cfg_q <= cfg_d;
      opt_q <= opt_d;
      prot_q <= prot_d;
      boot_bgnd_q <= boot_bgnd_d;
      rdata_q <= rdata_d;
      unlock_q <= unlock_d;
      key_st_q <= key_st_d;
      key_cnt_q <= key_cnt_d;
      key_bad_q <= key_bad_d;
      mem_rdata_q <= mem_rdata_d;
    end
  end

  fscd_clkdiv u_clkdiv (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_run(div_q[fscd_pkg::DIV_LOADED_BIT]),
    .i_prescale(div_q[fscd_pkg::DIV_PRESCALE_BIT]),
    .i_divisor(div_q[5:0]),
    .o_fclk_tick(o_fclk_tick)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_read_zero_gate: assert property (
    (i_mem_valid && !i_mem_write && blocked) |=> (o_mem_rdata == 8'h00))
    else $error("blocked read returned data");
  a_write_drop_gate: assert property (
    (i_mem_write && blocked) |-> !o_mem_valid)
    else $error("blocked write reached the array");
  a_sec_decode_map: assert property (
    !unlock_q |-> (secure == (opt_q[1:0] != 2'h2)))
    else $error("security decode wrong");
  a_debug_when_secure: assert property (secure |-> !o_debug_enable)
    else $error("debug module enabled while secure");
  a_div_write_once: assert property (
    (div_q[7] && wr_acc && i_paddr == fscd_pkg::OFF_CLK_DIV)
    |=> $stable(div_q))
    else $error("divider changed after first write");
  a_div_first_load: assert property (
    (!div_q[7] && wr_acc && i_paddr == fscd_pkg::OFF_CLK_DIV)
    |=> (div_q[7] && div_q[6:0] == $past(i_pwdata[6:0])))
    else $error("first divider write not loaded");
  a_cmd_needs_div: assert property (!div_q[7] |-> !o_cmd_start)
    else $error("command started without divisor");
  a_key_unlocks: assert property (
    (key_fall && key_st_q == KS_ENTRY && key_good) |=> !secure [*3])
    else $error("matching key did not unsecure");
  a_key_bad_hold: assert property (
    (key_fall && !key_good && !i_blank_check_ok) |=> $stable(unlock_q))
    else $error("bad key changed security");
  a_prot_app_write: assert property (
    (wr_acc && !i_pfrom_debug) |=> $stable(prot_q))
    else $error("application wrote protection");
  a_blank_unlocks: assert property (i_blank_check_ok |=> !secure)
    else $error("blank check did not unsecure");

endmodule : fscd_top

/* sim/fscd_array_model.sv */
// Purpose: Flash and RAM array seen behind the security gate.
// Assumes: The array answers in the same cycle as the request.
// Notes: The data pattern hangs on the address, so a blocked read
//   that returns zero cannot pass for real array data.
module fscd_array_model (
  input wire logic [15:0] i_addr,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // The pattern is never zero in the address ranges the bench reads.
  assign o_rdata = i_addr[7:0] ^ 8'hA5;

endmodule : fscd_array_model

/* sim/testbench.sv */
// Purpose: Self-checking bench for the security gate and clock divider.
// Assumes: Zero wait state APB, single-cycle memory requests.
// Notes: Each scenario is one task that judges its own results.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pdbg = 1'b0, bmp = 1'b1, mvalid = 1'b0;
  logic mwrite = 1'b0, msec = 1'b0, mdbg = 1'b0, mtgt = 1'b0;
  logic blank = 1'b0, dreq = 1'b0, breq = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [7:0] nv_opt = 8'h83, nv_prot = 8'hDE, mwdata = 8'h00;
  logic [7:0] ardata, mrdata;
  logic [15:0] maddr = 16'h0000;
  logic [63:0] key = 64'h0123_4567_89AB_CDEF;
  logic pready, pslverr, fwd_o, cmd_o, ref_o, sec_o, den_o, bgd_o;
  logic pee_o, tick_o;
  int errors = 0, total_checks = 0, cycles = 0;
  logic [31:0] rd;
  logic er, fwd, cmd, refd;
  logic [7:0] mrd;

  fscd_array_model fscd_array_model_inst (.i_addr(maddr), .o_rdata(ardata));

  fscd_top fscd_top_inst (
    .i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pfrom_debug(pdbg), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_nonvolatile_option_byte(nv_opt),
    .i_nonvolatile_protect_byte(nv_prot),
    .i_backdoor_key_locations(key), .i_background_mode_pin(bmp),
    .i_mem_valid(mvalid), .i_mem_write(mwrite), .i_mem_addr(maddr),
    .i_mem_wdata(mwdata), .i_mem_from_secure(msec),
    .i_mem_from_debug(mdbg), .i_mem_target_secure(mtgt),
    .i_array_rdata(ardata), .i_blank_check_ok(blank),
    .i_debug_enable_req(dreq), .i_background_req(breq),
    .o_mem_valid(fwd_o), .o_mem_rdata(mrdata), .o_cmd_start(cmd_o),
    .o_cmd_refused(ref_o), .o_secure(sec_o), .o_debug_enable(den_o),
    .o_background_enter(bgd_o), .o_program_erase_enable(pee_o),
    .o_fclk_tick(tick_o)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // The slowest scenario needs about one thousand cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      summarize();
    end
  end

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d, input logic dbg,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pdbg <= dbg;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic mem(input logic w, input logic [15:0] a,
                     input logic [7:0] d, input logic s, input logic g,
                     input logic t);
    @(posedge clk);
    mvalid <= 1'b1;
    mwrite <= w;
    maddr <= a;
    mwdata <= d;
    msec <= s;
    mdbg <= g;
    mtgt <= t;
    @(negedge clk);
    fwd = fwd_o;
    cmd = cmd_o;
    refd = ref_o;
    @(posedge clk);
    mvalid <= 1'b0;
    @(negedge clk);
    mrd = mrdata;
  endtask : mem

  task automatic do_reset(input logic [7:0] opt, input logic pin);
    @(posedge clk);
    rst <= 1'b1;
    nv_opt <= opt;
    bmp <= pin;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bmp <= 1'b1;
  endtask : do_reset

  // One request per key byte, with an idle cycle between bytes.
  task automatic enter_key(input logic [63:0] k, input logic dbg);
    apb(1'b1, fscd_pkg::OFF_CONFIG, 8'h20, 1'b0, rd, er);
    @(posedge clk);
    for (int n = 0; n < 8; n++) begin
      mem(1'b1, 16'hFFB0 + 16'(n), k[8*n+:8], ~dbg, dbg, 1'b1);
      check("key write forwarded", 0, fwd);
    end
    apb(1'b1, fscd_pkg::OFF_CONFIG, 8'h00, 1'b0, rd, er);
    @(negedge clk);
  endtask : enter_key

  task automatic t_reset_state;
    for (int p = 0; p < 4; p++) begin
      do_reset({6'h20, 2'(p)}, 1'b1);
      @(negedge clk);
      check("secure", 32'(p != 2), 32'(sec_o));
      apb(1'b0, fscd_pkg::OFF_OPTION, 8'h00, 1'b0, rd, er);
      check("option", {24'h0, 6'h20, 2'(p)}, rd);
    end
    do_reset(8'hBF, 1'b1);
    apb(1'b0, fscd_pkg::OFF_OPTION, 8'h00, 1'b0, rd, er);
    check("option copy", 32'h83, rd);
    apb(1'b0, fscd_pkg::OFF_CLK_DIV, 8'h00, 1'b0, rd, er);
    check("divider reset", 32'h0, rd);
    apb(1'b0, 12'h020, 8'h00, 1'b0, rd, er);
    check("unmapped error", 1, er);
    check("unmapped data", 32'h0, rd);
    $display("test reset_state done");
  endtask : t_reset_state

  task automatic t_block;
    mem(1'b0, 16'h8010, 8'h00, 1'b0, 1'b1, 1'b1);
    check("debug read", 32'h0, mrd);
    mem(1'b1, 16'h8010, 8'h11, 1'b0, 1'b1, 1'b1);
    check("debug write fwd", 0, fwd);
    mem(1'b0, 16'h0080, 8'h00, 1'b0, 1'b1, 1'b0);
    check("register read", 32'h25, mrd);
    mem(1'b0, 16'h8010, 8'h00, 1'b1, 1'b0, 1'b1);
    check("secure code read", 32'hB5, mrd);
    mem(1'b1, 16'h8010, 8'h11, 1'b1, 1'b0, 1'b1);
    check("refused", 1, refd);
    check("started", 0, cmd);
    @(posedge clk);
    dreq <= 1'b1;
    breq <= 1'b1;
    @(negedge clk);
    check("debug enable", 0, den_o);
    check("background", 0, bgd_o);
    @(posedge clk);
    dreq <= 1'b0;
    breq <= 1'b0;
    $display("test block done");
  endtask : t_block

  task automatic t_divider;
    int n;
    // 100 MHz / 8 / 63 stays inside the flash clock band.
    apb(1'b1, fscd_pkg::OFF_CLK_DIV, 8'h3E | 8'h40, 1'b0, rd, er);
    apb(1'b1, fscd_pkg::OFF_CLK_DIV, 8'h05, 1'b0, rd, er);
    apb(1'b0, fscd_pkg::OFF_CLK_DIV, 8'h00, 1'b0, rd, er);
    check("divider", 32'hFE, rd);
    check("prog enable", 1, pee_o);
    n = 0;
    while (tick_o !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tick_o !== 1'b1 && n < 2000);
    check("tick period", 504, n);
    $display("test divider done");
  endtask : t_divider

  task automatic t_protect;
    apb(1'b1, fscd_pkg::OFF_PROTECT, 8'h55, 1'b0, rd, er);
    apb(1'b0, fscd_pkg::OFF_PROTECT, 8'h00, 1'b0, rd, er);
    check("protect app", 32'hDE, rd);
    apb(1'b1, fscd_pkg::OFF_PROTECT, 8'h55, 1'b1, rd, er);
    apb(1'b0, fscd_pkg::OFF_PROTECT, 8'h00, 1'b0, rd, er);
    check("protect debug", 32'h55, rd);
    $display("test protect done");
  endtask : t_protect

  task automatic t_keys;
    enter_key(key ^ 64'h0000_0100_0000_0000, 1'b0);
    check("bad key", 1, sec_o);
    enter_key(key, 1'b1);
    check("debug key", 1, sec_o);
    enter_key(key, 1'b0);
    check("good key", 0, sec_o);
    apb(1'b0, fscd_pkg::OFF_OPTION, 8'h00, 1'b0, rd, er);
    check("option unlocked", 32'h82, rd);
    mem(1'b0, 16'h8010, 8'h00, 1'b0, 1'b1, 1'b1);
    check("open read", 32'hB5, mrd);
    mem(1'b1, 16'hFFB0, 8'h11, 1'b1, 1'b0, 1'b1);
    check("cmd start", 1, cmd);
    $display("test keys done");
  endtask : t_keys

  task automatic t_no_backdoor;
    do_reset(8'h03, 1'b0);
    @(posedge clk);
    breq <= 1'b1;
    @(negedge clk);
    check("pin entry", 1, bgd_o);
    check("prog enable reset", 0, pee_o);
    enter_key(key, 1'b0);
    check("backdoor off", 1, sec_o);
    @(posedge clk);
    blank <= 1'b1;
    @(posedge clk);
    blank <= 1'b0;
    @(negedge clk);
    check("blank check", 0, sec_o);
    @(posedge clk);
    dreq <= 1'b1;
    @(negedge clk);
    check("debug enable", 1, den_o);
    $display("test no_backdoor done");
  endtask : t_no_backdoor

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset_state();
    t_block();
    t_divider();
    t_protect();
    t_keys();
    t_no_backdoor();
    summarize();
  end

endmodule : testbench
